// [src/qaw_checker.sv]
// Function
// - three then one correct: decrement, new question
// - summary error ORs all watchdog errors
// - four answers in window one fail
// - under four answers by end: fail
// - other fourth-answer splits fail, same question
// - answer error set on any wrong answer
// - two-bit answer tally, four completes cycle
// - act when failure count reaches limit
// - programmable window size split in two
// - reset defaults option 0, poly 0, seed 9
`timescale 1ns/100ps
`default_nettype none
`include "qaw_map.svh"

module qaw_checker #(
    // cycles in one window step; 16 ms at 40 MHz by default
    parameter int unsigned WIN_STEP_CYC = `QAW_WIN_STEP_CYC,
    // width of the window timer
    parameter int TMR_W = 32,
    // width of the failure counter
    parameter int FAIL_W = 5
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic reg_wr,
    input wire logic [7:0] reg_addr,
    input wire qaw_pkg::qaw_byte_t reg_wdata,
    output qaw_pkg::qaw_byte_t reg_rdata,
    input wire qaw_pkg::qaw_byte_t expected_answer,
    input wire logic [3:0] question_value,
    output logic [1:0] answer_tally,
    output logic new_question,
    output logic watchdog_action,
    output logic [FAIL_W-1:0] fail_count,
    output logic answer_error_flag,
    output logic watchdog_error_summary,
    output logic watchdog_flavour_select,
    output logic [1:0] answer_option,
    output logic [1:0] question_poly,
    output logic [3:0] poly_seed,
    output logic in_window_two
);
    import qaw_pkg::*;

    // address match helper, used by every register decode
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    // configuration registers
    qaw_byte_t setup_one_reg; // window size select
    qaw_byte_t setup_two_reg; // run bit and flavour select
    qaw_byte_t rst_pulse_reg; // failure limit field
    qaw_byte_t qa_setup_reg; // answer option, polynomial, seed

    // cycle state
    qaw_phase_e phase_reg, phase_next; // current window
    logic [TMR_W-1:0] tmr_reg; // cycles since the cycle began
    logic [1:0] tally_reg; // answers taken this cycle
    logic [2:0] w1_cnt_reg; // answers taken in window one
    logic wrong_reg; // a wrong answer seen this cycle
    logic [FAIL_W-1:0] fail_reg; // failure counter
    logic aerr_reg; // answer error of last finished cycle
    logic serr_reg; // sequence error of last finished cycle
    logic newq_reg; // question advance pulse
    logic act_reg; // watchdog action pulse
    qaw_byte_t rdata_reg; // read data

    // writes land on the edge that samples reg_wr, no wait states
    // unmapped offsets miss every decode and are dropped
    // decode of the register port
    wire wr_one = reg_wr && hit(reg_addr, `QAW_ADDR_SETUP_ONE);
    wire wr_two = reg_wr && hit(reg_addr, `QAW_ADDR_SETUP_TWO);
    wire wr_pulse = reg_wr && hit(reg_addr, `QAW_ADDR_RST_PULSE);
    wire wr_qa = reg_wr && hit(reg_addr, `QAW_ADDR_QA_SETUP);
    wire wr_ans = reg_wr && hit(reg_addr, `QAW_ADDR_ANSWER);

    // only the multi-answer flavour is built here, so a set
    // flavour bit parks the checker in idle
    // watchdog enabled and in multi-answer flavour
    wire run = setup_two_reg[`QAW_RUN_BIT];
    wire flavour = setup_two_reg[`QAW_FLAVOUR_BIT];
    wire active = run && !flavour;

    wire [2:0] win_sel = setup_one_reg[`QAW_WIN_SEL_HI:`QAW_WIN_SEL_LO];
    wire [TMR_W-1:0] step = TMR_W'(WIN_STEP_CYC);
    wire [TMR_W-1:0] win_len = step << win_sel;
    // first response window is the first half of the whole window
    wire [TMR_W-1:0] half_len = win_len >> 1;
    wire tmr_half = (tmr_reg == half_len - TMR_W'(1));
    wire tmr_end = (tmr_reg == win_len - TMR_W'(1));

    // answer arriving this cycle while a window is open
    wire ans_take = wr_ans && active && (phase_reg != QAW_IDLE);
    wire ans_ok = (reg_wdata == expected_answer);
    wire fourth = ans_take && (tally_reg == `QAW_LAST_SLOT);
    // window two closes with answers missing
    wire timeout = active && (phase_reg == QAW_WIN2) && tmr_end && !fourth;
    wire cyc_end = fourth || timeout;
    // wrong-answer history including the answer now arriving
    wire wrong_now = wrong_reg || (ans_take && !ans_ok);

    // only a clean three-then-one sequence passes
    wire good = fourth && (phase_reg == QAW_WIN2) && (w1_cnt_reg == `QAW_W1_GOOD) && !wrong_now;
    // every other ending is a failure
    wire fail = cyc_end && !good;

    // the counter only moves at a cycle end; a pass steps down,
    // any other ending steps up
    // failure limit is the programmed field plus one
    wire [FAIL_W-1:0] limit = FAIL_W'(rst_pulse_reg[`QAW_LIMIT_HI:`QAW_LIMIT_LO]) + FAIL_W'(1);
    // hold at zero on a decrement
    wire [FAIL_W-1:0] fail_dec = (fail_reg == '0) ? fail_reg : fail_reg - FAIL_W'(1);
    // counter stops at its top value instead of wrapping
    wire [FAIL_W-1:0] fail_inc = (&fail_reg) ? fail_reg : fail_reg + FAIL_W'(1);
    wire [FAIL_W-1:0] fail_next = good ? fail_dec : (fail ? fail_inc : fail_reg);
    // reaching the limit on a failure
    wire hit_limit = fail && (fail_next == limit);

    // status byte: summary, answer error, tally and the
    // question nibble handed in by the generator
    // read mux
    wire [7:0] q_stat = {watchdog_error_summary, aerr_reg, tally_reg, question_value};
    wire [7:0] rd_mux = hit(reg_addr, `QAW_ADDR_SETUP_ONE) ? setup_one_reg :
                        hit(reg_addr, `QAW_ADDR_SETUP_TWO) ? setup_two_reg :
                        hit(reg_addr, `QAW_ADDR_RST_PULSE) ? rst_pulse_reg :
                        hit(reg_addr, `QAW_ADDR_QA_SETUP) ? qa_setup_reg :
                        hit(reg_addr, `QAW_ADDR_QUESTION) ? q_stat : 8'h00;

    // a fourth answer always reopens window one, so an early
    // finish never skips straight into window two
    // window phase sequencing
    always_comb begin
        phase_next = phase_reg;
        case (phase_reg)
            // wait for the watchdog to be enabled
            QAW_IDLE: begin
                if (active) begin
                    phase_next = QAW_WIN1;
                end
            end
            // first half, or early close by a fourth answer
            QAW_WIN1: begin
                if (!active) begin
                    phase_next = QAW_IDLE;
                end else if (fourth) begin
                    phase_next = QAW_WIN1;
                end else if (tmr_half) begin
                    phase_next = QAW_WIN2;
                end
            end
            // second half, closed by the fourth answer or time
            QAW_WIN2: begin
                if (!active) begin
                    phase_next = QAW_IDLE;
                end else if (cyc_end) begin
                    phase_next = QAW_WIN1;
                end
            end
            // unused code falls back to idle
            default: begin
                phase_next = QAW_IDLE;
            end
        endcase
    end

    // settings may change while running; the window length
    // follows at once, which can cut the current cycle short
    // configuration registers
    always_ff @(posedge clk) begin
        if (rst) begin
            setup_one_reg <= `QAW_RST_SETUP_ONE;
            setup_two_reg <= `QAW_RST_SETUP_TWO;
            rst_pulse_reg <= `QAW_RST_RST_PULSE;
            qa_setup_reg <= `QAW_RST_QA_SETUP;
        end else begin
            if (wr_one) begin
                setup_one_reg <= reg_wdata;
            end
            if (wr_two) begin
                setup_two_reg <= reg_wdata;
            end
            if (wr_pulse) begin
                rst_pulse_reg <= reg_wdata;
            end
            if (wr_qa) begin
                qa_setup_reg <= reg_wdata;
            end
        end
    end

    // phase and window timer; timer restarts with each cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            phase_reg <= QAW_IDLE;
            tmr_reg <= '0;
        end else begin
            phase_reg <= phase_next;
            // cycle restarts at the window end
            // held in idle too, so window one gets its full half;
            // counting there would shorten only the first window
            if (!active || cyc_end || (phase_reg == QAW_IDLE)) begin
                // fresh cycle or stopped watchdog starts from zero
                tmr_reg <= '0;
            end else begin
                tmr_reg <= tmr_reg + TMR_W'(1);
            end
        end
    end

    // history is wiped on the closing edge itself, so the next
    // answer may follow on the very next write
    // answer tally and per-cycle history
    always_ff @(posedge clk) begin
        if (rst) begin
            tally_reg <= 2'h0;
            w1_cnt_reg <= 3'h0;
            wrong_reg <= 1'b0;
        end else if (!active || cyc_end) begin
            // history cleared for the new cycle
            tally_reg <= 2'h0;
            w1_cnt_reg <= 3'h0;
            wrong_reg <= 1'b0;
        end else if (ans_take) begin
            tally_reg <= tally_reg + 2'h1;
            // answers in window one are counted apart
            if (phase_reg == QAW_WIN1) begin
                w1_cnt_reg <= w1_cnt_reg + 3'h1;
            end
            wrong_reg <= wrong_now;
        end
    end

    // pass, fail and limit are decided in the cycle of the last
    // answer or of the window end; the pulses follow one edge
    // later from their own flip-flops
    // outcome of a finished cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            fail_reg <= '0;
            aerr_reg <= 1'b0;
            serr_reg <= 1'b0;
            newq_reg <= 1'b0;
            act_reg <= 1'b0;
        end else begin
            fail_reg <= fail_next;
            if (cyc_end) begin
                // stays clear when every answer was right
                aerr_reg <= wrong_now;
                serr_reg <= fail;
            end
            // advance the question only after a good sequence
            newq_reg <= good;
            // one pulse as the limit is reached
            act_reg <= hit_limit;
        end
    end

    // read data is registered to keep the port glitch free
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_reg <= 8'h00;
        end else begin
            rdata_reg <= rd_mux;
        end
    end

    // every output is a flip-flop except the summary and the
    // window flag, which are plain decodes of registers
    // outputs
    assign reg_rdata = rdata_reg;
    assign answer_tally = tally_reg;
    assign new_question = newq_reg;
    assign watchdog_action = act_reg;
    assign fail_count = fail_reg;
    assign answer_error_flag = aerr_reg;
    // summary is the OR of every error
    assign watchdog_error_summary = aerr_reg || serr_reg || (fail_reg >= limit);
    assign watchdog_flavour_select = flavour;
    assign answer_option = qa_setup_reg[`QAW_ANS_OPT_HI:`QAW_ANS_OPT_LO];
    assign question_poly = qa_setup_reg[`QAW_POLY_HI:`QAW_POLY_LO];
    assign poly_seed = qa_setup_reg[`QAW_SEED_HI:`QAW_SEED_LO];
    assign in_window_two = (phase_reg == QAW_WIN2);

endmodule // qaw_checker
`default_nettype wire

// [src/qaw_map.svh]
`ifndef QAW_MAP_SVH
`define QAW_MAP_SVH

// register offsets on the serial register port
`define QAW_ADDR_SETUP_ONE 8'h13
`define QAW_ADDR_SETUP_TWO 8'h14
`define QAW_ADDR_RST_PULSE 8'h16
`define QAW_ADDR_QA_SETUP 8'h2d
`define QAW_ADDR_ANSWER 8'h2e
`define QAW_ADDR_QUESTION 8'h2f

// reset values
`define QAW_RST_SETUP_ONE 8'h00
`define QAW_RST_SETUP_TWO 8'h00
`define QAW_RST_RST_PULSE 8'h00
// answer option 0, polynomial 0, seed 9
`define QAW_RST_QA_SETUP 8'h09

// field positions
`define QAW_WIN_SEL_HI 7
`define QAW_WIN_SEL_LO 5
`define QAW_RUN_BIT 7
`define QAW_FLAVOUR_BIT 0
`define QAW_LIMIT_HI 3
`define QAW_LIMIT_LO 0
`define QAW_ANS_OPT_HI 7
`define QAW_ANS_OPT_LO 6
`define QAW_POLY_HI 5
`define QAW_POLY_LO 4
`define QAW_SEED_HI 3
`define QAW_SEED_LO 0

// answer counts that shape a correct sequence
`define QAW_W1_GOOD 3'h3
`define QAW_LAST_SLOT 2'h3

// timing: smallest window step, in ms, at a 40 MHz clock
`define QAW_WIN_STEP_MS 16
`define QAW_CLK_KHZ 40000
`define QAW_WIN_STEP_CYC (`QAW_WIN_STEP_MS * `QAW_CLK_KHZ)

`endif

// [src/qaw_pkg.sv]
`default_nettype none
package qaw_pkg;
    // phase of the watchdog cycle, gray coded along idle, window 1, window 2
    typedef enum logic [1:0] {
        QAW_IDLE = 2'b00,
        QAW_WIN1 = 2'b01,
        QAW_WIN2 = 2'b11
    } qaw_phase_e;
    // one register byte
    typedef logic [7:0] qaw_byte_t;
endpackage
`default_nettype wire

// [test/qaw_checker_properties.sv]
`timescale 1ns/100ps
`default_nettype none
module qaw_checker_props #(
    parameter int FAIL_W = 5
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic reg_wr,
    input wire logic [7:0] reg_addr,
    input wire qaw_pkg::qaw_byte_t reg_wdata,
    input wire logic [1:0] answer_tally,
    input wire logic new_question,
    input wire logic watchdog_action,
    input wire logic [FAIL_W-1:0] fail_count,
    input wire logic answer_error_flag,
    input wire logic watchdog_error_summary,
    input wire logic [3:0] poly_seed,
    input wire logic in_window_two
);
    import qaw_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // the pulse is sampled one edge after the edge that took the last answer
    property p_pass_shape; new_question |-> $past(answer_tally) == 2'h3 && $past(in_window_two); endproperty
    a_pass_shape: assert property (p_pass_shape) else $error("new question without full sequence");
    property p_pass_clean; new_question |-> !watchdog_error_summary && !answer_error_flag; endproperty
    a_pass_clean: assert property (p_pass_clean) else $error("error bits set after good sequence");
    property p_pass_dec; new_question |-> fail_count == (($past(fail_count) == '0) ? '0 : $past(fail_count) - 1'b1); endproperty
    a_pass_dec: assert property (p_pass_dec) else $error("failure count not decremented");
    property p_tally_step; answer_tally != $past(answer_tally) |-> answer_tally == $past(answer_tally) + 2'h1 || answer_tally == 2'h0; endproperty
    a_tally_step: assert property (p_tally_step) else $error("answer tally jumped");
    property p_aerr_at_end; $changed(answer_error_flag) |-> answer_tally == 2'h0; endproperty
    a_aerr_at_end: assert property (p_aerr_at_end) else $error("answer error moved mid cycle");
    property p_action_pulse; watchdog_action |-> (fail_count == $past(fail_count) + 1'b1) ##1 !watchdog_action; endproperty
    a_action_pulse: assert property (p_action_pulse) else $error("action without failure step");
    property p_seed_write; reg_wr && reg_addr == 8'h2d |=> {4'h0, poly_seed} == ($past(reg_wdata) & 8'h0f); endproperty
    a_seed_write: assert property (p_seed_write) else $error("seed field not written");
    property p_fail_summary; fail_count > $past(fail_count) |-> watchdog_error_summary; endproperty
    a_fail_summary: assert property (p_fail_summary) else $error("summary clear after failure");
    c_pass: cover property (new_question);
    c_action: cover property (watchdog_action);
    c_aerr: cover property ($rose(answer_error_flag));
endmodule // qaw_checker_props
bind qaw_checker qaw_checker_props #(.FAIL_W(FAIL_W)) qaw_checker_props_i (
    .clk, .rst, .reg_wr, .reg_addr, .reg_wdata, .answer_tally, .new_question, .watchdog_action,
    .fail_count, .answer_error_flag, .watchdog_error_summary, .poly_seed, .in_window_two
);
`default_nettype wire

// [test/qaw_qgen.sv]
`timescale 1ns/100ps
`default_nettype none
module qaw_qgen (
    input wire logic clk,
    input wire logic rst,
    input wire logic new_question,
    input wire logic [1:0] answer_tally,
    output logic [3:0] question_value,
    output qaw_pkg::qaw_byte_t expected_answer
);
    import qaw_pkg::*;
    // question moves on only after a passing cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            question_value <= 4'h0;
        end else if (new_question) begin
            question_value <= question_value + 4'h1;
        end
    end
    // arbitrary mix, differs per slot so order mistakes show
    assign expected_answer = {question_value ^ 4'h5, 2'h2, answer_tally};
endmodule // qaw_qgen
`default_nettype wire

// [test/qaw_checker_tb.sv]
`timescale 1ns/100ps
`default_nettype none
module qaw_checker_tb;
    import qaw_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic reg_wr = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    qaw_byte_t reg_wdata = 8'h00;
    qaw_byte_t reg_rdata, expected_answer;
    logic [3:0] question_value, poly_seed;
    logic [1:0] answer_tally, answer_option, question_poly;
    logic new_question, watchdog_action, answer_error_flag, watchdog_error_summary;
    logic watchdog_flavour_select, in_window_two;
    logic [4:0] fail_count;
    logic [7:0] ra [4] = '{8'h13, 8'h14, 8'h16, 8'h2d};
    logic [7:0] rv [4] = '{8'hdd, 8'h80, 8'h0e, 8'h0a};
    int errors = 0;
    int cmp_count = 0;
    int cycles = 0;
    int nq_seen = 0;
    int act_seen = 0;
    int w2_cycles = 0;
    // short window step keeps a cycle at 512 clocks
    qaw_checker #(.WIN_STEP_CYC(8)) qaw_checker_i (.clk, .rst, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata,
        .expected_answer, .question_value, .answer_tally, .new_question, .watchdog_action, .fail_count,
        .answer_error_flag, .watchdog_error_summary, .watchdog_flavour_select, .answer_option,
        .question_poly, .poly_seed, .in_window_two);
    qaw_qgen qaw_qgen_i (.clk, .rst, .new_question, .answer_tally, .question_value, .expected_answer);
    always #12.5 clk = ~clk;
    // pulse counters and hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        nq_seen <= nq_seen + int'(new_question === 1'b1);
        act_seen <= act_seen + int'(watchdog_action === 1'b1);
        if (cycles == 20000) begin
            errors = errors + 1;
            give_verdict();
        end
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1;
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(posedge clk);
        #1;
        reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        #1;
        reg_addr = a;
        @(posedge clk);
        #1;
        check(reg_rdata, exp);
    endtask
    // n answers, right or wrong
    task automatic ans(input int n, input bit ok);
        repeat (n) wr(8'h2e, ok ? expected_answer : ~expected_answer);
    endtask
    task automatic wait_w2(input logic lvl);
        repeat (600) begin
            if (in_window_two !== lvl) begin
                @(posedge clk);
                #1;
            end
        end
    endtask
    // three clocks let the counts settle after the pulse ends
    task automatic status(input logic [4:0] fc, input logic ae, input logic su, input int nq);
        repeat (3) @(posedge clk);
        #1;
        check({3'h0, fail_count}, {3'h0, fc});
        check({7'h0, answer_error_flag}, {7'h0, ae});
        check({7'h0, watchdog_error_summary}, {7'h0, su});
        check(8'(nq_seen), 8'(nq));
        $display("test done at %0t", $time);
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge clk);
        #1;
        rst = 1'b0;
        rd(8'h2d, 8'h09);
        check({answer_option, question_poly, poly_seed}, 8'h09);
        rd(8'h20, 8'h00);
        for (int i = 0; i < 4; i++) wr(ra[i], rv[i]);
        for (int i = 0; i < 4; i++) rd(ra[i], rv[i]);
        check({answer_option, question_poly, poly_seed}, 8'h0a);
        check({7'h0, watchdog_flavour_select}, 8'h00);
        // host sends three, then one in window two
        ans(3, 1'b1);
        wait_w2(1'b1);
        ans(1, 1'b1);
        status(5'h0, 1'b0, 1'b0, 1);
        ans(4, 1'b1);
        status(5'h1, 1'b0, 1'b1, 1);
        ans(3, 1'b0);
        wait_w2(1'b1);
        ans(1, 1'b1);
        status(5'h2, 1'b1, 1'b1, 1);
        ans(2, 1'b1);
        check({6'h0, answer_tally}, 8'h02);
        wait_w2(1'b1);
        // window two is half of the 512-cycle window
        while (in_window_two === 1'b1 && w2_cycles < 600) begin
            @(posedge clk);
            #1;
            w2_cycles++;
        end
        check(8'(w2_cycles >> 8), 8'h01);
        check(8'(w2_cycles), 8'h00);
        wait_w2(1'b0);
        status(5'h3, 1'b0, 1'b1, 1);
        ans(3, 1'b1);
        wait_w2(1'b1);
        ans(1, 1'b1);
        status(5'h2, 1'b0, 1'b0, 2);
        repeat (13) ans(4, 1'b0);
        status(5'hf, 1'b1, 1'b1, 2);
        check(8'(act_seen), 8'h01);
        rd(8'h2f, {2'b11, 2'b00, question_value});
        // flavour bit set: the checker idles and refuses answers
        wr(8'h14, 8'h81);
        check({7'h0, watchdog_flavour_select}, 8'h01);
        ans(1, 1'b1);
        check({6'h0, answer_tally}, 8'h00);
        rst = 1'b1;
        repeat (4) @(posedge clk);
        #1;
        rst = 1'b0;
        check({3'h0, fail_count}, 8'h00);
        rd(8'h2d, 8'h09);
        check({answer_option, question_poly, poly_seed}, 8'h09);
        give_verdict();
    end
endmodule // qaw_checker_tb
`default_nettype wire
